// ===== rtl/asm_host.sv
// Purpose: host controller driving a four-lane async sram module through its pins
// Assumes: lane selects may be tied per bank outside; one cycle setup, hold and turnaround
// Notes: one request at a time; reqReady high only in idle
//
// Summary of operation
// [R1] device writes during select and strobe overlap
// [R2] write begins both low, ends first release
// [R3] data held past the ending rising edge
// [R4] device floats data while output enable high; the bench model drives inverted data instead
// [R5] same timing for every bus width
// [R6] address valid long enough before write end
// [R7] data sampled after output enable access time
// [R8] word use: all lane selects driven together
// [R9] word use: separate strobe per byte lane
// [R10] half-word use: two banks of two lanes
// [R11] byte use: up to four single lane banks
// [R12] unused lane controls held inactive high
// [R13] per-die standby, write, read, disable modes
// [R14] each lane responds to own select and strobe
`timescale 1ns/1ps
module asm_host #(
	parameter int ADDR_W = asm_pkg::ADDR_W,
	parameter int LANES = asm_pkg::LANES
)(
	input wire logic clk,
	input wire logic srst,
	input wire logic clkEn,
	// user side
	input wire logic reqValid,
	input wire logic reqWrite,
	input wire logic [ADDR_W-1:0] reqAddr,
	input wire logic [LANES-1:0] reqLanes,
	input wire logic [LANES*8-1:0] reqWdata,
	output logic reqReady,
	output logic rspValid,
	output logic [LANES*8-1:0] rspRdata,
	// module pins
	output logic [ADDR_W-1:0] memAddr,
	output logic [LANES-1:0] lane_select_n,
	output logic [LANES-1:0] lane_write_strobe_n,
	output logic outEnable_n,
	output logic [LANES*8-1:0] memDataOut,
	output logic memDataOe,
	input wire logic [LANES*8-1:0] memDataIn
);
	asm_pkg::asm_state_e state;
	logic [asm_pkg::CNT_W-1:0] cnt;
	logic [LANES-1:0] lanes;
	logic take;
	logic cntDone;
	logic writeLast;
	logic readLast;

	// a zero lane mask would select nothing, so it is never taken
	assign take = (state == asm_pkg::ASM_IDLE) && reqValid && reqReady && (reqLanes != '0);
	assign cntDone = (cnt == '0);
	assign writeLast = (state == asm_pkg::ASM_HOLD) && cntDone;
	assign readLast = (state == asm_pkg::ASM_READ) && cntDone;

	// sequencer
	always_ff @(posedge clk)
	begin
		if (srst)
			state <= asm_pkg::ASM_IDLE;
		else if (clkEn)
		begin
			case (state)
				asm_pkg::ASM_IDLE:
				begin
					if (take && reqWrite)
						state <= asm_pkg::ASM_SETUP;
					else if (take)
						state <= asm_pkg::ASM_READ;
				end
				asm_pkg::ASM_SETUP:
				begin
					if (cntDone)
						state <= asm_pkg::ASM_PULSE;
				end
				asm_pkg::ASM_PULSE:
				begin
					if (cntDone)
						state <= asm_pkg::ASM_HOLD; // R6
				end
				asm_pkg::ASM_HOLD:
				begin
					if (cntDone)
						state <= asm_pkg::ASM_TURN;
				end
				asm_pkg::ASM_READ:
				begin
					if (cntDone)
						state <= asm_pkg::ASM_TURN;
				end
				asm_pkg::ASM_TURN:
				begin
					// lets the module float its outputs before the next drive
					if (cntDone)
						state <= asm_pkg::ASM_IDLE;
				end
				default:
					state <= asm_pkg::ASM_IDLE;
			endcase
		end
	end

	// one counter times every phase; each phase loads the length of the next
	always_ff @(posedge clk)
	begin
		if (srst)
			cnt <= '0;
		else if (clkEn)
		begin
			case (state)
				asm_pkg::ASM_IDLE:
				begin
					if (take && reqWrite)
						cnt <= asm_pkg::CNT_W'(asm_pkg::SETUP_CYC - 1);
					else if (take)
						cnt <= asm_pkg::CNT_W'(asm_pkg::READ_ACCESS_CYC - 1);
				end
				asm_pkg::ASM_SETUP:
				begin
					if (!cntDone)
						cnt <= cnt - 1'b1;
					else
						cnt <= asm_pkg::CNT_W'(asm_pkg::WRITE_PULSE_CYC - 1); // R6
				end
				asm_pkg::ASM_PULSE:
				begin
					if (!cntDone)
						cnt <= cnt - 1'b1; // R6
					else
						cnt <= asm_pkg::CNT_W'(asm_pkg::HOLD_CYC - 1); // R3
				end
				asm_pkg::ASM_HOLD, asm_pkg::ASM_READ:
				begin
					if (!cntDone)
						cnt <= cnt - 1'b1;
					else
						cnt <= asm_pkg::CNT_W'(asm_pkg::TURN_CYC - 1);
				end
				asm_pkg::ASM_TURN:
				begin
					if (!cntDone)
						cnt <= cnt - 1'b1;
				end
				default:
					cnt <= '0;
			endcase
		end
	end

	// ready only in idle, and dropped on the edge that takes a request
	always_ff @(posedge clk)
	begin
		if (srst)
			reqReady <= 1'b0;
		else if (clkEn)
			reqReady <= (state == asm_pkg::ASM_IDLE) && !take;
	end

	// address, lane mask and write data stand for the whole cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			memAddr <= '0;
			lanes <= '0;
			memDataOut <= '0;
		end
		else if (clkEn && take)
		begin
			memAddr <= reqAddr; // R6
			lanes <= reqLanes;
			if (reqWrite)
				memDataOut <= reqWdata; // R3
		end
	end

	// only requested lanes selected; others stay high
	always_ff @(posedge clk)
	begin
		if (srst)
			lane_select_n <= '1; // R12
		else if (clkEn)
		begin
			if (take)
				lane_select_n <= ~reqLanes; // R8 R10 R11 R12
			else if (writeLast || readLast)
				lane_select_n <= '1;
		end
	end

	// strobe rises first and ends the write; select follows a cycle later
	always_ff @(posedge clk)
	begin
		if (srst)
			lane_write_strobe_n <= '1; // R12
		else if (clkEn)
		begin
			if ((state == asm_pkg::ASM_SETUP) && cntDone)
				lane_write_strobe_n <= ~lanes; // R2 R9
			else if ((state == asm_pkg::ASM_PULSE) && cntDone)
				lane_write_strobe_n <= '1; // R2
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			outEnable_n <= 1'b1;
		else if (clkEn)
		begin
			if (take && !reqWrite)
				outEnable_n <= 1'b0;
			else if (readLast)
				outEnable_n <= 1'b1;
		end
	end

	// data held past the ending edge of the strobe
	always_ff @(posedge clk)
	begin
		if (srst)
			memDataOe <= 1'b0;
		else if (clkEn)
		begin
			if (take && reqWrite)
				memDataOe <= 1'b1;
			else if (writeLast)
				memDataOe <= 1'b0; // R3
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			rspValid <= 1'b0;
		else if (clkEn)
			rspValid <= writeLast || readLast;
	end

	// no synchroniser: the pins stand still for the whole access time before this sample
	always_ff @(posedge clk)
	begin
		if (srst)
			rspRdata <= '0;
		else if (clkEn && readLast)
			rspRdata <= memDataIn;
	end
endmodule

// ===== rtl/asm_pkg.sv
// Purpose: constants for the host-side controller of a four-lane async sram module
// Assumes: clk at 40 MHz; times in ns with the slower grade figures
// Notes: cycle counts derived from times; least times round up
package asm_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W = 19;
	localparam int LANES = 4;
	localparam int LANE_W = 8;
	localparam int DATA_W = LANES * LANE_W;
	// write cycle times, ns
	localparam int WRITE_CYCLE_NS = 20;
	localparam int ADDR_SETUP_NS = 2;
	localparam int ADDR_VALID_TO_WRITE_END_NS = 14;
	localparam int DATA_SETUP_NS = 9;
	localparam int SELECT_TO_WRITE_END_NS = 12;
	localparam int WRITE_PULSE_NS = 12;
	localparam int DATA_HOLD_NS = 2;
	// read cycle times, ns
	localparam int READ_CYCLE_NS = 20;
	localparam int SELECT_ACCESS_NS = 20;
	localparam int OUT_ENABLE_TO_DATA_VALID_NS = 11;
	localparam int OUT_DISABLE_TO_HIGHZ_NS = 9;
	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction
	localparam int SETUP_CYC = ns2cyc(ADDR_SETUP_NS);
	localparam int PULSE_CYC_A = ns2cyc(ADDR_VALID_TO_WRITE_END_NS);
	localparam int PULSE_CYC_B = ns2cyc(WRITE_PULSE_NS > SELECT_TO_WRITE_END_NS ?
		WRITE_PULSE_NS : SELECT_TO_WRITE_END_NS);
	localparam int PULSE_CYC_C = ns2cyc(DATA_SETUP_NS);
	localparam int WRITE_PULSE_CYC = (PULSE_CYC_A > PULSE_CYC_B) ?
		((PULSE_CYC_A > PULSE_CYC_C) ? PULSE_CYC_A : PULSE_CYC_C) :
		((PULSE_CYC_B > PULSE_CYC_C) ? PULSE_CYC_B : PULSE_CYC_C);
	localparam int HOLD_CYC = ns2cyc(DATA_HOLD_NS);
	localparam int READ_ACC_A = ns2cyc(SELECT_ACCESS_NS);
	localparam int READ_ACC_B = ns2cyc(OUT_ENABLE_TO_DATA_VALID_NS);
	localparam int READ_ACCESS_CYC = (READ_ACC_A > READ_ACC_B) ? READ_ACC_A : READ_ACC_B;
	localparam int TURN_CYC = ns2cyc(OUT_DISABLE_TO_HIGHZ_NS);
	localparam int CNT_W = 4;
	typedef enum logic [2:0] {
		ASM_IDLE = 3'b000,
		ASM_SETUP = 3'b001,
		ASM_PULSE = 3'b011,
		ASM_HOLD = 3'b010,
		ASM_READ = 3'b100,
		ASM_TURN = 3'b110
	} asm_state_e;
endpackage

// ===== testbench/asm_host_bench.sv
`timescale 1ns/1ps
// Purpose: sram host bench
// Assumes: clkEn lowered only while idle
// Notes: row is write, address, lanes, data
module asm_host_bench;
	logic clk = 0, srst = 1, clkEn = 1, reqValid = 0, reqWrite = 0, reqReady, rspValid;
	logic outEnable_n, memDataOe;
	logic [18:0] reqAddr = 0, memAddr;
	logic [3:0] reqLanes = 0, lane_select_n, lane_write_strobe_n;
	logic [31:0] reqWdata = 0, rspRdata, memDataOut, memDataIn, q;
	logic [55:0] rows [6] = '{56'h80005f11223344, 56'h800051000000aa, 56'h80005cbbcc0000,
		56'h5fbbcc33aa, 56'h8000af0123cdef, 56'h5fbbcc33aa};
	int fail_count = 0, checks = 0, cyc = 0;
	asm_host uut (.*);
	asm_sram_model mem (.a(memAddr), .s(lane_select_n), .w(lane_write_strobe_n),
		.g(outEnable_n), .d(memDataIn), .q(q));
	assign memDataIn = memDataOe ? memDataOut : q;
	initial forever #12.5 clk = ~clk;
	always @(posedge clk)
		if (cyc++ == 400) finish_test();
	task chk(input logic [31:0] a, b);
		checks++;
		fail_count += a !== b;
		if (a !== b) $display("wrong value %0t %h", $time, a);
	endtask
	task finish_test;
		fail_count += cyc > 400;
		$display("checks %0d fails %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task op(input logic [55:0] r);
		do @(posedge clk) #1; while (reqReady !== 1);
		{reqWrite, reqAddr, reqLanes, reqWdata} = r;
		reqValid = 1;
		@(posedge clk) #1 reqValid = 0;
		do @(posedge clk) #1; while (rspValid !== 1);
		if (!r[55]) chk(rspRdata, r[31:0]);
		$display("op %h done", r);
	endtask
	initial
	begin
		repeat (20) @(posedge clk) #1;
		srst = 0;
		foreach (rows[i]) op(rows[i]);
		reqLanes = 0;
		reqValid = 1;
		repeat (3) @(posedge clk) #1;
		chk({reqReady, lane_select_n}, 5'h1f);
		srst = 1;
		@(posedge clk) #1;
		chk({reqReady, rspValid, outEnable_n, memDataOe}, 4'h2);
		clkEn = 0;
		srst = 0;
		repeat (3) @(posedge clk) #1;
		// frozen after release: not ready yet, pins parked
		chk({reqReady, lane_select_n, outEnable_n}, 6'h1f);
		clkEn = 1;
		op(56'haf0123cdef);
		$display("zero mask, reset and freeze done");
		finish_test();
	end
endmodule

// ===== testbench/asm_host_props.sv
`timescale 1ns/1ps
// Purpose: host pin checks
// Assumes: clkEn lowered only while idle
// Notes: latencies of the fixed walk
module asm_host_props #(parameter int LANES = 4, parameter int ADDR_W = 19)(
	input wire logic clk, srst, reqValid, reqWrite, reqReady, rspValid, outEnable_n, memDataOe,
	input wire logic [LANES-1:0] reqLanes, lane_select_n, lane_write_strobe_n,
	input wire logic [ADDR_W-1:0] memAddr
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire take = reqValid && reqReady && reqLanes != 0;
	wire stb = !(&lane_write_strobe_n);
	sequence s_wr;
		lane_select_n == ~$past(reqLanes) ##1 lane_write_strobe_n == ~$past(reqLanes, 2);
	endsequence
	property p_wr; take && reqWrite |=> s_wr ##1 !stb ##1 rspValid; endproperty
	a_wr: assert property (p_wr) else $error("write walk");
	property p_rd; take && !reqWrite |=> !outEnable_n ##1 rspValid; endproperty
	a_rd: assert property (p_rd) else $error("read walk");
	property p_pr; (~lane_write_strobe_n & lane_select_n) == 0; endproperty
	a_pr: assert property (p_pr) else $error("lone strobe");
	property p_oe; !outEnable_n |-> !memDataOe && !stb; endproperty
	a_oe: assert property (p_oe) else $error("bus clash");
	property p_end; $rose(!stb) |-> memDataOe && !(&lane_select_n); endproperty
	a_end: assert property (p_end) else $error("data hold");
	property p_len; $rose(stb) |-> $stable(memAddr) ##1 !stb && $stable(memAddr); endproperty
	a_len: assert property (p_len) else $error("pulse");
	property p_idle; reqReady |-> &lane_select_n && outEnable_n && !memDataOe; endproperty
	a_idle: assert property (p_idle) else $error("idle pins");
	property p_gap; rspValid |=> !reqReady ##1 reqReady; endproperty
	a_gap: assert property (p_gap) else $error("turnaround");
endmodule
bind asm_host asm_host_props #(.LANES(LANES), .ADDR_W(ADDR_W)) chk (.*);

// ===== testbench/asm_sram_model.sv
`timescale 1ns/1ps
// Purpose: four-lane async sram
// Assumes: only address bits 3:0 decoded
// Notes: lanes not reading drive inverted data; read data settles after the access time
module asm_sram_model(
	input wire logic [18:0] a,
	input wire logic [3:0] s,
	input wire logic [3:0] w,
	input wire logic g,
	input wire logic [31:0] d,
	output wire logic [31:0] q
);
	localparam int ACCESS_NS = 20;
	logic [7:0] m [4][16];
	always_latch
		for (int i = 0; i < 4; i++)
			if (!s[i] && !w[i]) m[i][a[3:0]] <= d[8*i+:8];
	for (genvar i = 0; i < 4; i++)
	begin : g_lane
		assign #(ACCESS_NS) q[8*i+:8] = !s[i] && w[i] && !g ? m[i][a[3:0]] : ~m[i][a[3:0]];
	end
endmodule
